//--- tb_top.sv
// self-checking bench for the timer output compare and pwm stage
`timescale 1ns/1ns
module tb_top;
  import tocp_pkg::*;
  logic clk_sys;
  logic rst;
  tocp_pkg::tocp_bus_req_type req;
  logic [15:0] rdata;
  logic timer_input_pin;
  tocp_pkg::tocp_pin_type pin;
  logic compare_irq;
  int n_fail;
  int checked;
  int hi_a;
  int ir_a;
  int hi_b;
  int ir_b;
  logic [15:0] v;

  // =====================================================================
  // clock, reset and device
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  tocp_core u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_req(req),
    .rdata(rdata),
    .timer_input_pin(timer_input_pin),
    .channel_pin_output(pin),
    .compare_irq(compare_irq)
  );

  // =====================================================================
  // field builders and port helpers
  function automatic logic [15:0] cr(input logic en, input logic dir, input logic [1:0] al,
                                     input logic one_pulse, input logic rel_pre, input logic trig);
    return (16'(en) << CTRL_EN_BIT) | (16'(dir) << CTRL_DIR_BIT) | (16'(al) << CTRL_ALIGN_LSB)
      | (16'(one_pulse) << CTRL_ONE_PULSE_BIT) | (16'(rel_pre) << CTRL_RELOAD_PRE_BIT)
      | (16'(trig) << CTRL_TRIGMODE_BIT);
  endfunction

  function automatic logic [15:0] md(input logic [2:0] cm, input logic pe, input logic fe,
                                     input logic [1:0] ds);
    return (16'(ds) << MODE_DIRSEL_LSB) | (16'(cm) << MODE_CMP_LSB) | (16'(pe) << MODE_PE_BIT)
      | (16'(fe) << MODE_FE_BIT);
  endfunction

  // strobes drop after one cycle, so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts pin-high cycles and irq pulses over a fixed window
  task automatic meas(input int n, output int hi, output int ir);
    hi = 0;
    ir = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (pin.out === 1'b1) hi++;
      if (compare_irq === 1'b1) ir++;
    end
  endtask

  // pin lags the reference by one cycle, so let two edges pass
  task automatic pinchk(input logic oe, input logic out);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({14'h0000, pin.oe, pin.out}, {14'h0000, oe, out});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset();
    rd(ADDR_RELOAD, v);
    chk(v, RESET_RELOAD);
    rd(ADDR_COUNT, v);
    chk(v, RESET_ZERO);
    rd(4'hf, v);
    chk(v, 16'h0000);
    chk({14'h0000, pin.oe, pin.out}, 16'h0000);
  endtask

  task automatic t_force();
    wr(ADDR_OUTCFG, 16'h0001);
    wr(ADDR_MODE, md(CMP_FORCE_HIGH, 1'b0, 1'b0, DIRSEL_OUTPUT));
    pinchk(1'b1, 1'b1);
    wr(ADDR_OUTCFG, 16'h0003);
    pinchk(1'b1, 1'b0);
    wr(ADDR_OUTCFG, 16'h0000);
    pinchk(1'b0, 1'b1);
    wr(ADDR_OUTCFG, 16'h0001);
    // channel set as input: no forcing and no pin drive
    wr(ADDR_MODE, md(CMP_FORCE_LOW, 1'b0, 1'b0, 2'h1));
    pinchk(1'b0, 1'b1);
    wr(ADDR_MODE, md(CMP_FORCE_LOW, 1'b0, 1'b0, DIRSEL_OUTPUT));
    pinchk(1'b1, 1'b0);
  endtask

  // forced high while the counter runs: flag still sets, irq gated by enable
  task automatic t_match_irq();
    wr(ADDR_RELOAD, 16'h0008);
    wr(ADDR_COMPARE, 16'h0003);
    wr(ADDR_MODE, md(CMP_FORCE_HIGH, 1'b0, 1'b0, DIRSEL_OUTPUT));
    wr(ADDR_CTRL, cr(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0));
    meas(20, hi_a, ir_a);
    meas(45, hi_a, ir_a);
    chk(16'(hi_a), 16'd45);
    chk(16'(ir_a), 16'd0);
    rd(ADDR_STATUS, v);
    chk(v, 16'h0003);
    wr(ADDR_STATUS, 16'h0001);
    wr(ADDR_IRQEN, 16'h0001);
    meas(45, hi_a, ir_a);
    chk(16'(ir_a), 16'd5);
  endtask

  task automatic t_oc();
    wr(ADDR_MODE, md(CMP_SET_INACTIVE, 1'b0, 1'b0, DIRSEL_OUTPUT));
    meas(20, hi_a, ir_a);
    pinchk(1'b1, 1'b0);
    wr(ADDR_MODE, md(CMP_SET_ACTIVE, 1'b0, 1'b0, DIRSEL_OUTPUT));
    meas(20, hi_a, ir_a);
    pinchk(1'b1, 1'b1);
    wr(ADDR_MODE, md(CMP_FROZEN, 1'b0, 1'b0, DIRSEL_OUTPUT));
    meas(90, hi_a, ir_a);
    chk(16'(hi_a), 16'd90);
    wr(ADDR_MODE, md(CMP_TOGGLE, 1'b0, 1'b0, DIRSEL_OUTPUT));
    meas(20, hi_a, ir_a);
    meas(90, hi_a, ir_a);
    chk(16'(hi_a), 16'd45);
    wr(ADDR_MODE, md(CMP_SET_ACTIVE, 1'b0, 1'b0, DIRSEL_OUTPUT));
    meas(20, hi_a, ir_a);
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_EVENT, 16'h0001);
    pinchk(1'b1, 1'b1);
  endtask

  // stopped counter below compare: leaving frozen must still set the reference
  task automatic t_leave_frozen();
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_MODE, md(CMP_FORCE_LOW, 1'b0, 1'b0, DIRSEL_OUTPUT));
    wr(ADDR_MODE, md(CMP_FROZEN, 1'b0, 1'b0, DIRSEL_OUTPUT));
    pinchk(1'b1, 1'b0);
    wr(ADDR_MODE, md(CMP_PWM1, 1'b0, 1'b0, DIRSEL_OUTPUT));
    pinchk(1'b1, 1'b1);
  endtask

  // preloads set and update pulsed before start, then duty over ten periods
  task automatic t_pwm(input logic [2:0] cm, input logic dir, input logic [15:0] cv,
                       input int exp);
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_MODE, md(cm, 1'b1, 1'b0, DIRSEL_OUTPUT));
    wr(ADDR_COMPARE, cv);
    wr(ADDR_EVENT, 16'h0001);
    wr(ADDR_CTRL, cr(1'b1, dir, 2'h0, 1'b0, 1'b1, 1'b0));
    meas(30, hi_a, ir_a);
    meas(90, hi_a, ir_a);
    chk(16'(hi_a), 16'(exp));
  endtask

  task automatic t_ctr(input logic [1:0] al, output int hi, output int ir);
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_EVENT, 16'h0001);
    wr(ADDR_CTRL, cr(1'b1, 1'b0, al, 1'b0, 1'b1, 1'b0));
    meas(40, hi, ir);
    meas(144, hi, ir);
  endtask

  task automatic t_cdir();
    wr(ADDR_RELOAD, 16'h0100);
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
    wr(ADDR_EVENT, 16'h0001);
    wr(ADDR_CTRL, cr(1'b1, 1'b0, 2'h1, 1'b0, 1'b1, 1'b0));
    wr(ADDR_COUNT, 16'h0100);
    rd(ADDR_CTRL, v);
    chk(16'(v[CTRL_DIR_BIT]), 16'h0001);
    wr(ADDR_COUNT, 16'h0000);
    rd(ADDR_CTRL, v);
    chk(16'(v[CTRL_DIR_BIT]), 16'h0000);
    wr(ADDR_COUNT, 16'h0200);
    rd(ADDR_CTRL, v);
    chk(16'(v[CTRL_DIR_BIT]), 16'h0000);
  endtask

  // one pulse started by a trigger edge; counter must stop itself at rollover
  task automatic t_one_pulse(input logic fe, output int hi);
    int ir;
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
    wr(ADDR_RELOAD, 16'h0008);
    wr(ADDR_COMPARE, 16'h0003);
    wr(ADDR_MODE, md(CMP_PWM2, 1'b1, fe, DIRSEL_OUTPUT));
    wr(ADDR_EVENT, 16'h0001);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CTRL, cr(1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b1));
    meas(10, hi, ir);
    @(posedge clk_sys) timer_input_pin <= 1'b1;
    meas(40, hi, ir);
    @(posedge clk_sys) timer_input_pin <= 1'b0;
    rd(ADDR_CTRL, v);
    chk(16'(v[CTRL_EN_BIT]), 16'h0000);
    rd(ADDR_COUNT, v);
    chk(v, 16'h0000);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    rst = 1'b1;
    req = '0;
    timer_input_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_force();
    t_match_irq();
    t_oc();
    t_leave_frozen();
    t_pwm(CMP_PWM1, 1'b0, 16'h0003, 30);
    t_pwm(CMP_PWM1, 1'b0, 16'h0000, 0);
    t_pwm(CMP_PWM1, 1'b0, 16'h0009, 90);
    t_pwm(CMP_PWM2, 1'b0, 16'h0003, 60);
    t_pwm(CMP_PWM1, 1'b1, 16'h0003, 40);
    t_pwm(CMP_PWM1, 1'b1, 16'h0009, 90);
    t_pwm(CMP_PWM2, 1'b1, 16'h0003, 50);
    t_pwm(CMP_PWM1, 1'b0, 16'h0003, 30);
    t_ctr(2'h1, hi_a, ir_a);
    t_ctr(2'h3, hi_b, ir_b);
    chk(16'(hi_a), 16'(hi_b));
    chk(16'(ir_b), 16'(2 * ir_a));
    chk(16'(ir_a > 0), 16'h0001);
    t_ctr(2'h2, hi_b, ir_b);
    chk(16'(hi_b), 16'(hi_a));
    t_cdir();
    t_one_pulse(1'b0, hi_a);
    // pulse spans the compare count through the reload count before rollover
    chk(16'(hi_a), 16'd6);
    t_one_pulse(1'b1, hi_b);
    chk(16'(hi_b > hi_a), 16'h0001);
    complete_run();
  end

  // hang guard: a run past its budget counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule

//--- tocp_core.sv
// module: one timer channel with counter, compare output stage, pwm and one-pulse
// =====================================================================
// Notes on behaviour
// - mode 101 with output direction forces reference high, pin to active level
// - mode 100 forces reference low, pin inactive
// - compare and match flag keep running while output is forced
// - on match: 000 hold, 001 active, 010 inactive, 011 toggle
// - match sets flag; interrupt only with channel interrupt enable set
// - preload clear: compare takes effect now; set: on update event
// - update event never changes reference in compare modes; one count resolution
// - pwm mode 1 is 110, pwm mode 2 is 111
// - pin driven only with output enable; polarity picks active level
// - pwm reference changes only on compare result change, leaving frozen or a fast-enabled trigger edge
// - pwm1 up: high while count below compare; zero compare held low
// - pwm1 down: low while count above compare; compare over reload held high
// - edge aligned: direction low counts up, high counts down
// - nonzero alignment is centre mode; value picks flag direction
// - counter writes in centre mode: above reload keep dir, 0 or reload set dir
// - one-pulse clears counter enable at next hardware update event (not a software update)
// - one-pulse delay is compare counts, length reload minus compare plus one
// - trigger edge in trigger mode sets counter enable
// - fast enable in pwm modes drives match level on trigger
// - shadow compare register is what the counter is compared with
`timescale 1ns/1ns
module tocp_core
  import tocp_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tocp_pkg::tocp_bus_req_type bus_req,
  output logic [15:0] rdata,
  input wire logic timer_input_pin,
  output tocp_pkg::tocp_pin_type channel_pin_output,
  output logic compare_irq
);
  import tocp_pkg::*;

  // =====================================================================
  // registers
  logic counter_enable_bit_reg;
  logic dir_reg;
  logic [1:0] alignment_select_reg;
  logic single_pulse_bit_reg;
  logic reload_preload_enable_reg;
  logic trig_mode_reg;
  logic [1:0] channel_direction_select_reg;
  tocp_cmp_mode_type compare_mode_field_reg;
  logic compare_preload_enable_reg;
  logic fast_trigger_enable_reg;
  logic output_enable_bit_reg;
  logic output_polarity_bit_reg;
  logic [CW-1:0] compare_value_reg;
  logic [CW-1:0] compare_shadow_reg;
  logic [CW-1:0] reload_value_reg;
  logic [CW-1:0] reload_shadow_reg;
  logic [CW-1:0] count_value_reg;
  logic compare_match_flag_reg;
  logic compare_irq_enable_reg;
  logic channel_reference_reg;
  logic pwm_level_prev_reg;
  tocp_cmp_mode_type mode_prev_reg;
  logic [2:0] trig_sync_reg;

  logic wr_ctrl, wr_mode, wr_cmp, wr_rel, wr_cnt, wr_stat, sw_update;
  logic update_evt, at_top, at_bottom, match, flag_dir_ok, trig_edge, pwm1_level;
  logic pwm_level, is_pwm, is_output, centre;

  assign wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CTRL;
  assign wr_mode = bus_req.wr && bus_req.addr == ADDR_MODE;
  assign wr_cmp = bus_req.wr && bus_req.addr == ADDR_COMPARE;
  assign wr_rel = bus_req.wr && bus_req.addr == ADDR_RELOAD;
  assign wr_cnt = bus_req.wr && bus_req.addr == ADDR_COUNT;
  assign wr_stat = bus_req.wr && bus_req.addr == ADDR_STATUS;
  assign sw_update = bus_req.wr && bus_req.addr == ADDR_EVENT && bus_req.wdata[EVT_UPDATE_BIT];

  // =====================================================================
  // trigger input: two-stage synchroniser, edge taken from the synced stages only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_sync_reg <= 3'h0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], timer_input_pin};
    end
  end
  assign trig_edge = trig_sync_reg[1] && !trig_sync_reg[2] && trig_mode_reg;

  // =====================================================================
  // counter core
  assign centre = alignment_select_reg != 2'h0;
  // centre mode turns only at the reload value: a count written above it keeps its direction
  assign at_top = centre ? count_value_reg == reload_shadow_reg :
                  count_value_reg >= reload_shadow_reg;
  assign at_bottom = count_value_reg == '0;
  // hardware update: overflow going up, underflow going down, or software request
  assign update_evt = sw_update || (counter_enable_bit_reg &&
                      ((!dir_reg && at_top) || (dir_reg && at_bottom)));

  // count value and direction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_value_reg <= '0;
      dir_reg <= 1'b0;
    end else if (wr_cnt) begin
      count_value_reg <= bus_req.wdata[CW-1:0];
      // direction follows the written endpoint, no update event raised
      if (centre && bus_req.wdata[CW-1:0] == '0) begin
        dir_reg <= 1'b0;
      end else if (centre && bus_req.wdata[CW-1:0] == reload_shadow_reg) begin
        dir_reg <= 1'b1;
      end
    end else if (wr_ctrl && !centre) begin
      dir_reg <= bus_req.wdata[CTRL_DIR_BIT];
    end else if (wr_ctrl && bus_req.wdata[CTRL_ALIGN_LSB +: 2] == 2'h0) begin
      dir_reg <= bus_req.wdata[CTRL_DIR_BIT];
    end else if (sw_update) begin
      count_value_reg <= dir_reg ? reload_shadow_reg : '0;
    end else if (counter_enable_bit_reg) begin
      if (!dir_reg) begin
        if (at_top) begin
          // centre mode turns round at the top instead of wrapping
          count_value_reg <= centre ? count_value_reg - 1'b1 : '0;
          if (centre) begin
            dir_reg <= 1'b1;
          end
        end else begin
          count_value_reg <= count_value_reg + 1'b1;
        end
      end else begin
        if (at_bottom) begin
          count_value_reg <= centre ? count_value_reg + 1'b1 : reload_shadow_reg;
          if (centre) begin
            dir_reg <= 1'b0;
          end
        end else begin
          count_value_reg <= count_value_reg - 1'b1;
        end
      end
    end
  end

  // control register; enable cleared by one-pulse update, set by trigger
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      counter_enable_bit_reg <= 1'b0;
      alignment_select_reg <= 2'h0;
      single_pulse_bit_reg <= 1'b0;
      reload_preload_enable_reg <= 1'b0;
      trig_mode_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        counter_enable_bit_reg <= bus_req.wdata[CTRL_EN_BIT];
        alignment_select_reg <= bus_req.wdata[CTRL_ALIGN_LSB +: 2];
        single_pulse_bit_reg <= bus_req.wdata[CTRL_ONE_PULSE_BIT];
        reload_preload_enable_reg <= bus_req.wdata[CTRL_RELOAD_PRE_BIT];
        trig_mode_reg <= bus_req.wdata[CTRL_TRIGMODE_BIT];
      end else if (trig_edge) begin
        counter_enable_bit_reg <= 1'b1;
      end else if (single_pulse_bit_reg && update_evt && !sw_update) begin
        counter_enable_bit_reg <= 1'b0;
      end
    end
  end

  // =====================================================================
  // channel configuration and preload registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_direction_select_reg <= DIRSEL_OUTPUT;
      compare_mode_field_reg <= CMP_FROZEN;
      compare_preload_enable_reg <= 1'b0;
      fast_trigger_enable_reg <= 1'b0;
      output_enable_bit_reg <= 1'b0;
      output_polarity_bit_reg <= 1'b0;
      compare_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        channel_direction_select_reg <= bus_req.wdata[MODE_DIRSEL_LSB +: 2];
        compare_mode_field_reg <= tocp_cmp_mode_type'(bus_req.wdata[MODE_CMP_LSB +: 3]);
        compare_preload_enable_reg <= bus_req.wdata[MODE_PE_BIT];
        fast_trigger_enable_reg <= bus_req.wdata[MODE_FE_BIT];
      end
      if (bus_req.wr && bus_req.addr == ADDR_OUTCFG) begin
        output_enable_bit_reg <= bus_req.wdata[OUT_EN_BIT];
        output_polarity_bit_reg <= bus_req.wdata[OUT_POL_BIT];
      end
      if (bus_req.wr && bus_req.addr == ADDR_IRQEN) begin
        compare_irq_enable_reg <= bus_req.wdata[0];
      end
    end
  end

  // buffer and shadow copies; preload defers the shadow to the update event
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_value_reg <= '0;
      compare_shadow_reg <= '0;
      reload_value_reg <= CW'(RESET_RELOAD);
      reload_shadow_reg <= CW'(RESET_RELOAD);
    end else begin
      if (wr_cmp) begin
        compare_value_reg <= bus_req.wdata[CW-1:0];
      end
      if (wr_rel) begin
        reload_value_reg <= bus_req.wdata[CW-1:0];
      end
      if (wr_cmp && !compare_preload_enable_reg) begin
        compare_shadow_reg <= bus_req.wdata[CW-1:0];
      end else if (update_evt) begin
        compare_shadow_reg <= compare_value_reg;
      end
      if (wr_rel && !reload_preload_enable_reg) begin
        reload_shadow_reg <= bus_req.wdata[CW-1:0];
      end else if (update_evt) begin
        reload_shadow_reg <= reload_value_reg;
      end
    end
  end

  // =====================================================================
  // compare and flag
  assign match = count_value_reg == compare_shadow_reg && counter_enable_bit_reg;
  // alignment 01 flags on the down slope, 10 on the up slope, 11 both
  always_comb begin
    flag_dir_ok = 1'b1;
    if (alignment_select_reg == 2'h1) begin
      flag_dir_ok = dir_reg;
    end else if (alignment_select_reg == 2'h2) begin
      flag_dir_ok = !dir_reg;
    end
  end

  // flag set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_match_flag_reg <= 1'b0;
      compare_irq <= 1'b0;
    end else begin
      if (match && flag_dir_ok) begin
        compare_match_flag_reg <= 1'b1;
      end else if (wr_stat && bus_req.wdata[0]) begin
        compare_match_flag_reg <= 1'b0;
      end
      compare_irq <= match && flag_dir_ok && compare_irq_enable_reg;
    end
  end

  // =====================================================================
  // pwm level from count, compare and direction
  always_comb begin
    if (!dir_reg) begin
      pwm1_level = count_value_reg < compare_shadow_reg;
    end else begin
      // compare above reload keeps the level high; zero duty not reachable
      pwm1_level = !(count_value_reg > compare_shadow_reg);
    end
  end
  assign pwm_level = compare_mode_field_reg == CMP_PWM2 ? !pwm1_level : pwm1_level;
  assign is_pwm = compare_mode_field_reg == CMP_PWM1 ||
                  compare_mode_field_reg == CMP_PWM2;
  assign is_output = channel_direction_select_reg == DIRSEL_OUTPUT;

  // reference: forced levels, compare actions and pwm edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_reference_reg <= 1'b0;
      pwm_level_prev_reg <= 1'b0;
      mode_prev_reg <= CMP_FROZEN;
    end else begin
      pwm_level_prev_reg <= pwm_level;
      mode_prev_reg <= compare_mode_field_reg;
      if (is_output) begin
        unique case (compare_mode_field_reg)
          CMP_FORCE_HIGH: channel_reference_reg <= 1'b1;
          CMP_FORCE_LOW: channel_reference_reg <= 1'b0;
          CMP_SET_ACTIVE: if (match) channel_reference_reg <= 1'b1;
          CMP_SET_INACTIVE: if (match) channel_reference_reg <= 1'b0;
          CMP_TOGGLE: if (match) channel_reference_reg <= !channel_reference_reg;
          CMP_FROZEN: channel_reference_reg <= channel_reference_reg;
          CMP_PWM1, CMP_PWM2: begin
            if (trig_edge && fast_trigger_enable_reg) begin
              // bypass: level as if the compare had matched
              channel_reference_reg <= compare_mode_field_reg == CMP_PWM2;
            end else if (pwm_level != pwm_level_prev_reg ||
                         mode_prev_reg == CMP_FROZEN) begin
              channel_reference_reg <= pwm_level;
            end
          end
        endcase
      end
    end
  end

  // pin stage: registered so the pin never glitches on a mode write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_pin_output <= '0;
    end else begin
      channel_pin_output.oe <= output_enable_bit_reg && is_output;
      channel_pin_output.out <= channel_reference_reg ^ output_polarity_bit_reg;
    end
  end

  // =====================================================================
  // read port, data valid in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL: rdata <= 16'({trig_mode_reg, reload_preload_enable_reg,
                      single_pulse_bit_reg, alignment_select_reg, dir_reg,
                      counter_enable_bit_reg});
        ADDR_MODE: rdata <= 16'({fast_trigger_enable_reg, compare_preload_enable_reg,
                      compare_mode_field_reg, channel_direction_select_reg});
        ADDR_OUTCFG: rdata <= 16'({output_polarity_bit_reg, output_enable_bit_reg});
        ADDR_COMPARE: rdata <= 16'(compare_value_reg);
        ADDR_RELOAD: rdata <= 16'(reload_value_reg);
        ADDR_COUNT: rdata <= 16'(count_value_reg);
        ADDR_STATUS: rdata <= 16'({channel_reference_reg, compare_match_flag_reg});
        ADDR_IRQEN: rdata <= 16'(compare_irq_enable_reg);
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // =====================================================================
  // checks
  a_force_high_ref: assert property (@(posedge clk_sys) disable iff (rst)
    is_output && compare_mode_field_reg == CMP_FORCE_HIGH |=> channel_reference_reg)
    else $error("forced high not applied");
  a_force_low_ref: assert property (@(posedge clk_sys) disable iff (rst)
    is_output && compare_mode_field_reg == CMP_FORCE_LOW |=> !channel_reference_reg)
    else $error("forced low not applied");
  a_match_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
    match && flag_dir_ok |=> compare_match_flag_reg)
    else $error("match flag not set");
  a_irq_needs_enable: assert property (@(posedge clk_sys) disable iff (rst)
    compare_irq |-> $past(compare_irq_enable_reg))
    else $error("irq without enable");
  a_toggle_on_match: assert property (@(posedge clk_sys) disable iff (rst)
    is_output && compare_mode_field_reg == CMP_TOGGLE && match
    |=> channel_reference_reg != $past(channel_reference_reg))
    else $error("toggle missed");
  a_pin_enable_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !output_enable_bit_reg ##1 !output_enable_bit_reg |-> !channel_pin_output.oe)
    else $error("pin driven while disabled");
  a_pulse_stops_count: assert property (@(posedge clk_sys) disable iff (rst)
    single_pulse_bit_reg && update_evt && !sw_update && !wr_ctrl && !trig_edge
    |=> !counter_enable_bit_reg)
    else $error("one pulse did not stop");
  a_trigger_starts: assert property (@(posedge clk_sys) disable iff (rst)
    trig_edge && !wr_ctrl |=> counter_enable_bit_reg)
    else $error("trigger did not start counter");
  a_direct_compare: assert property (@(posedge clk_sys) disable iff (rst)
    wr_cmp && !compare_preload_enable_reg |=> compare_shadow_reg == $past(bus_req.wdata[CW-1:0]))
    else $error("compare write not immediate");
  c_pwm1_run: cover property (@(posedge clk_sys) compare_mode_field_reg == CMP_PWM1 && match);
  c_centre_turn: cover property (@(posedge clk_sys) centre && at_top && counter_enable_bit_reg);
  c_fast_trigger: cover property (@(posedge clk_sys) trig_edge && fast_trigger_enable_reg);
  a_fast_trigger_ref: assert property (@(posedge clk_sys) disable iff (rst)
    is_output && is_pwm && trig_edge && fast_trigger_enable_reg
    |=> channel_reference_reg == $past(compare_mode_field_reg == CMP_PWM2))
    else $error("fast trigger level not applied");
  c_pulse_stop: cover property (@(posedge clk_sys)
    single_pulse_bit_reg && update_evt && counter_enable_bit_reg);
  c_leave_frozen: cover property (@(posedge clk_sys) is_pwm && mode_prev_reg == CMP_FROZEN);
endmodule

//--- tocp_pkg.sv
// package: constants and carrier types for the timer output compare and pwm stage
package tocp_pkg;
  // register indices of the plain port map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_OUTCFG = 4'h2;
  localparam logic [3:0] ADDR_COMPARE = 4'h3;
  localparam logic [3:0] ADDR_RELOAD = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQEN = 4'h7;
  localparam logic [3:0] ADDR_EVENT = 4'h8;
  // ctrl register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_ALIGN_LSB = 2;
  localparam int CTRL_ONE_PULSE_BIT = 4;
  localparam int CTRL_RELOAD_PRE_BIT = 5;
  localparam int CTRL_TRIGMODE_BIT = 6;
  // mode register fields
  localparam int MODE_DIRSEL_LSB = 0;
  localparam int MODE_CMP_LSB = 2;
  localparam int MODE_PE_BIT = 5;
  localparam int MODE_FE_BIT = 6;
  // output config fields
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_POL_BIT = 1;
  // event register: write one to generate an update
  localparam int EVT_UPDATE_BIT = 0;
  // reset values
  localparam logic [15:0] RESET_RELOAD = 16'hffff;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  // direction select code for output
  localparam logic [1:0] DIRSEL_OUTPUT = 2'h0;

  // compare mode codes
  typedef enum logic [2:0] {
    CMP_FROZEN = 3'h0,
    CMP_SET_ACTIVE = 3'h1,
    CMP_SET_INACTIVE = 3'h2,
    CMP_TOGGLE = 3'h3,
    CMP_FORCE_LOW = 3'h4,
    CMP_FORCE_HIGH = 3'h5,
    CMP_PWM1 = 3'h6,
    CMP_PWM2 = 3'h7
  } tocp_cmp_mode_type;

  // pin carrier
  typedef struct packed {
    logic out;
    logic oe;
  } tocp_pin_type;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tocp_bus_req_type;
endpackage
